/* File: pkg/hisc_params.svh */
// Register offsets, field positions and reset values of the host interface control bank.
`ifndef HISC_PARAMS_SVH
`define HISC_PARAMS_SVH

`define HISC_ADDR_W        12
`define HISC_OFF_CTRL2     12'h000
`define HISC_OFF_SYSCTL    12'h004
`define HISC_OFF_AUX       12'h008
`define HISC_OFF_STATUS    12'h00c
`define HISC_CTRL2_RST     8'h00
`define HISC_CTRL2_WMASK   8'hef
`define HISC_BIT_MASTER    0
`define HISC_BIT_CH3       1
`define HISC_BIT_CH4       2
`define HISC_BIT_SDE       3
`define HISC_BIT_RSVD      4
`define HISC_BIT_PULLUP    5
`define HISC_BIT_KWL_LO    6
`define HISC_BIT_KWL_HI    7
`define HISC_BIT_HIE       0
`define HISC_BIT_CH2       0
`define HISC_BIT_FGATE     1
`define HISC_BIT_SCMODE    0
`define HISC_BIT_GATED_ERR 1

`endif

/* File: pkg/hisc_pkg.sv */
// Types shared by the host interface control bank.
package hisc_pkg;
  typedef enum logic [1:0] {
    HISC_LVL_STD,
    HISC_LVL_ONE,
    HISC_LVL_TWO,
    HISC_LVL_THREE
  } hisc_level_e;
endpackage

/* File: hw/hisc_gate.sv */
// Combines a local enable with the mode-qualified master enable.
module hisc_gate (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Qualifiers
  input  wire logic master_ok,
  input  wire logic local_en,
  // Result
  output logic      gated_q
);
  logic gated_next;

  always_comb begin
    gated_next = master_ok & local_en;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gated_q <= 1'b0;
    end else begin
      gated_q <= gated_next;
    end
  end
endmodule

/* File: hw/hisc_top.sv */
// APB register bank controlling the host interface enables and port 6 input options.
`include "hisc_params.svh"
module hisc_top (
  // Clock and reset
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  // APB slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [`HISC_ADDR_W-1:0]    paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  // Device state and pins
  input  wire logic                       single_chip_mode,
  input  wire logic                       shutdown_input_pin,
  input  wire logic                       chan2_select_primary,
  input  wire logic                       chan2_select_alternate,
  input  wire logic                       host_reg_access_req,
  // Controls to the host interface and port 6
  output hisc_pkg::hisc_level_e           port6_input_level,
  output logic                            port6_pullup_limit,
  output logic                            host_if_active,
  output logic                            chan2_active,
  output logic                            chan3_active,
  output logic                            chan4_active,
  output logic                            fast_gate_active,
  output logic                            pins_shutdown,
  output logic                            chan2_select,
  output logic                            host_reg_access_grant
);
  logic [7:0]  host_if_system_control_reg;
  logic [7:0]  host_if_system_control_next;
  logic [1:0]  system_control_reg;
  logic [1:0]  system_control_next;
  logic [1:0]  aux_ctrl_reg;
  logic [1:0]  aux_ctrl_next;
  logic [31:0] prdata_next;
  logic        pslverr_next;
  logic        pready_next;
  logic        master_ok;
  logic        sd_gate;
  logic        ch2_gate;
  logic        fg_gate;
  logic        outs_next_sd;
  logic        sel_next;
  logic        grant_next;
  logic        acc;

  assign acc = psel & penable & pready;

  assign master_ok = host_if_system_control_reg[`HISC_BIT_MASTER] & single_chip_mode;

  // Register state: writes take effect on the completing access edge.
  always_comb begin
    host_if_system_control_next = host_if_system_control_reg;
    system_control_next         = system_control_reg;
    aux_ctrl_next               = aux_ctrl_reg;
    if (acc && pwrite) begin
      unique case (paddr)
        `HISC_OFF_CTRL2: begin
          host_if_system_control_next = pwdata[7:0] & `HISC_CTRL2_WMASK;
        end
        `HISC_OFF_SYSCTL: begin
          system_control_next[`HISC_BIT_HIE] = pwdata[`HISC_BIT_HIE];
        end
        `HISC_OFF_AUX: begin
          aux_ctrl_next = pwdata[1:0];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_if_system_control_reg <= `HISC_CTRL2_RST;
      system_control_reg         <= 2'h0;
      aux_ctrl_reg               <= 2'h0;
    end else begin
      host_if_system_control_reg <= host_if_system_control_next;
      system_control_reg         <= system_control_next;
      aux_ctrl_reg               <= aux_ctrl_next;
    end
  end

  // Bus answer: no wait state; pready and every read are registered in the setup cycle.
  always_comb begin
    pready_next  = psel & ~penable;
    prdata_next  = 32'h0;
    pslverr_next = 1'b0;
    if (psel && !penable) begin
      unique case (paddr)
        `HISC_OFF_CTRL2:  prdata_next = {24'h0, host_if_system_control_reg};
        `HISC_OFF_SYSCTL: prdata_next = {30'h0, system_control_reg};
        `HISC_OFF_AUX:    prdata_next = {30'h0, aux_ctrl_reg};
        `HISC_OFF_STATUS: prdata_next = {30'h0, host_if_active, single_chip_mode};
        default:          pslverr_next = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= pready_next;
      prdata  <= prdata_next;
      pslverr <= pslverr_next;
    end
  end

  hisc_gate u_ch4 (
    .pclk      (pclk),
    .presetn   (presetn),
    .master_ok (master_ok),
    .local_en  (host_if_system_control_reg[`HISC_BIT_CH4]),
    .gated_q   (chan4_active)
  );

  hisc_gate u_ch3 (
    .pclk      (pclk),
    .presetn   (presetn),
    .master_ok (master_ok),
    .local_en  (host_if_system_control_reg[`HISC_BIT_CH3]),
    .gated_q   (chan3_active)
  );

  hisc_gate u_ch2 (
    .pclk      (pclk),
    .presetn   (presetn),
    .master_ok (master_ok),
    .local_en  (aux_ctrl_reg[`HISC_BIT_CH2]),
    .gated_q   (chan2_active)
  );

  hisc_gate u_fg (
    .pclk      (pclk),
    .presetn   (presetn),
    .master_ok (master_ok),
    .local_en  (aux_ctrl_reg[`HISC_BIT_FGATE]),
    .gated_q   (fast_gate_active)
  );

  assign sd_gate  = master_ok & host_if_system_control_reg[`HISC_BIT_SDE];
  assign ch2_gate = master_ok & aux_ctrl_reg[`HISC_BIT_CH2];
  assign fg_gate  = aux_ctrl_reg[`HISC_BIT_FGATE];

  // Pin-facing controls, all registered so outputs come from flip-flops.
  always_comb begin
    outs_next_sd = sd_gate & shutdown_input_pin;
    sel_next     = ch2_gate & (fg_gate ? chan2_select_alternate : chan2_select_primary);
    grant_next   = host_reg_access_req & system_control_reg[`HISC_BIT_HIE];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port6_input_level     <= hisc_pkg::HISC_LVL_STD;
      port6_pullup_limit    <= 1'b0;
      host_if_active        <= 1'b0;
      pins_shutdown         <= 1'b0;
      chan2_select          <= 1'b0;
      host_reg_access_grant <= 1'b0;
    end else begin
      port6_input_level     <= hisc_pkg::hisc_level_e'(
        host_if_system_control_reg[`HISC_BIT_KWL_HI:`HISC_BIT_KWL_LO]);
      port6_pullup_limit    <= host_if_system_control_reg[`HISC_BIT_PULLUP];
      host_if_active        <= master_ok;
      pins_shutdown         <= outs_next_sd;
      chan2_select          <= sel_next;
      host_reg_access_grant <= grant_next;
    end
  end

  AST_RSVD_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    !host_if_system_control_reg[`HISC_BIT_RSVD])
    else $error("Reserved bit became set.");
  AST_CH4_MASTER: assert property (@(posedge pclk) disable iff (!presetn)
    chan4_active |-> $past(master_ok) && $past(host_if_system_control_reg[`HISC_BIT_CH4]))
    else $error("Channel 4 active without cause.");
  AST_CH3_FOLLOW: assert property (@(posedge pclk) disable iff (!presetn)
    (master_ok && host_if_system_control_reg[`HISC_BIT_CH3]) |=> chan3_active)
    else $error("Channel 3 did not turn on.");
  AST_MASTER_MODE: assert property (@(posedge pclk) disable iff (!presetn)
    !single_chip_mode |=> !host_if_active)
    else $error("Host interface active outside single-chip mode.");
  AST_SD_PIN: assert property (@(posedge pclk) disable iff (!presetn)
    (sd_gate && shutdown_input_pin) |=> pins_shutdown)
    else $error("Shutdown not applied.");
  AST_GRANT: assert property (@(posedge pclk) disable iff (!presetn)
    host_reg_access_grant |-> $past(system_control_reg[`HISC_BIT_HIE]))
    else $error("Access granted while disabled.");
  AST_PULLUP: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 port6_pullup_limit == $past(host_if_system_control_reg[`HISC_BIT_PULLUP]))
    else $error("Pull-up select mismatch.");
  AST_LEVEL: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 port6_input_level == $past(host_if_system_control_reg[`HISC_BIT_KWL_HI:`HISC_BIT_KWL_LO]))
    else $error("Input level mismatch.");
  AST_CH2SEL: assert property (@(posedge pclk) disable iff (!presetn)
    (!ch2_gate) |=> !chan2_select)
    else $error("Channel 2 select without enable.");
  AST_RESET_OFF: assert property (@(posedge pclk)
    $rose(presetn) |-> host_if_system_control_reg == `HISC_CTRL2_RST)
    else $error("Control register not cleared by reset.");
endmodule

/* File: bench/host_if_system_control_tb.sv */
// Self-checking bench for the host interface control register bank.
`include "hisc_params.svh"
module host_if_system_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                    pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [`HISC_ADDR_W-1:0] paddr;
  logic [31:0]             pwdata, prdata, rd;
  logic                    scm, sd_pin, cs_pri, cs_alt, acc_req;
  hisc_pkg::hisc_level_e   lvl;
  logic                    pul, hia, c2a, c3a, c4a, fga, psd, c2s, grant;
  int                      num_errors, compares, cycles;

  hisc_top u_hisc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .single_chip_mode(scm), .shutdown_input_pin(sd_pin),
    .chan2_select_primary(cs_pri), .chan2_select_alternate(cs_alt),
    .host_reg_access_req(acc_req), .port6_input_level(lvl), .port6_pullup_limit(pul),
    .host_if_active(hia), .chan2_active(c2a), .chan3_active(c3a), .chan4_active(c4a),
    .fast_gate_active(fga), .pins_shutdown(psd), .chan2_select(c2s),
    .host_reg_access_grant(grant));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task summarize;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // A hung handshake must not stall the run, so the bench gives up after a fixed budget.
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      summarize();
    end
  end

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Entered right after a rising edge; ends one idle edge after the transfer.
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic err);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No wait length is assumed; a slave that never answers is caught by the run's timeout.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    chk("pslverr", {31'h0, err}, {31'h0, pslverr & pready});
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b0);
  endtask

  task rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 1'b0);
    chk("read data", exp, rd);
  endtask

  // Bits: level[10:9] pullup host ch2 ch3 ch4 fastgate shutdown ch2sel grant.
  task outs(input logic [10:0] exp);
    repeat (2) @(posedge pclk);
    chk("outputs", {21'h0, exp}, {21'h0, lvl, pul, hia, c2a, c3a, c4a, fga, psd, c2s, grant});
  endtask

  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
    scm     = 1'b1;
    sd_pin  = 1'b0;
    cs_pri  = 1'b1;
    cs_alt  = 1'b0;
    acc_req = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(`HISC_OFF_CTRL2, 32'h0);
    rdc(`HISC_OFF_AUX, 32'h0);
    outs(11'h000);
    wr(`HISC_OFF_CTRL2, 32'hff);
    rdc(`HISC_OFF_CTRL2, 32'hef);
    outs(11'h7b0);
    sd_pin <= 1'b1;
    outs(11'h7b4);
    wr(`HISC_OFF_CTRL2, 32'h0e);
    outs(11'h000);
    wr(`HISC_OFF_CTRL2, 32'h05);
    outs(11'h090);
    wr(`HISC_OFF_CTRL2, 32'h03);
    outs(11'h0a0);
    for (int i = 0; i < 4; i++) begin
      wr(`HISC_OFF_CTRL2, {24'h0, i[1:0], i[0], 5'h01});
      outs({i[1:0], i[0], 1'b1, 7'h00});
    end
    scm <= 1'b0;
    outs(11'h700);
    rdc(`HISC_OFF_STATUS, 32'h0);
    scm <= 1'b1;
    outs(11'h780);
    wr(`HISC_OFF_AUX, 32'h1);
    outs(11'h7c2);
    wr(`HISC_OFF_AUX, 32'h3);
    outs(11'h7c8);
    cs_pri <= 1'b0;
    cs_alt <= 1'b1;
    acc_req <= 1'b1;
    outs(11'h7ca);
    wr(`HISC_OFF_SYSCTL, 32'h1);
    outs(11'h7cb);
    apb(1'b1, 12'h010, 32'hff, 1'b1);
    apb(1'b0, 12'h010, 32'h0, 1'b1);
    chk("unmapped read", 32'h0, rd);
    wr(`HISC_OFF_STATUS, 32'h0);
    rdc(`HISC_OFF_STATUS, 32'h3);
    rdc(`HISC_OFF_CTRL2, 32'he1);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(`HISC_OFF_CTRL2, 32'h0);
    rdc(`HISC_OFF_SYSCTL, 32'h0);
    outs(11'h000);
    summarize();
  end
endmodule
